// *** src/periph_disable_ctrl.sv ***
// apb register that gates clock and power of the brown-out, adc and comparator blocks
module periph_disable_ctrl (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       sys_reset_req,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [pgate_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       brownout_always_on_option,
  output pgate_pkg::periph_en_t           periph_clk_en,
  output pgate_pkg::periph_en_t           periph_pwr_en,
  output logic      [7:0]                 ctrl_value
);

  // ---------------------------------------------------------------
  // option bit synchroniser
  // ---------------------------------------------------------------
  logic opt_meta_q;
  logic opt_sync_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opt_meta_q <= 1'b0;
      opt_sync_q <= 1'b0;
    end
    else
    begin
      opt_meta_q <= brownout_always_on_option;
      opt_sync_q <= opt_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic        addr_hit;
  logic        setup_phase;
  logic        access_done;
  logic        write_fire;
  logic        pready_d;
  logic        pslverr_d;
  logic [31:0] prdata_d;

  assign addr_hit    = (paddr[pgate_pkg::ADDR_W-1:2] == pgate_pkg::CTRL_OFFSET[pgate_pkg::ADDR_W-1:2]);
  assign setup_phase = psel & ~penable & ~sys_reset_req;
  assign access_done = psel & penable & pready;
  // a pending system reset aborts the write; the register itself is not cleared
  assign write_fire  = access_done & pwrite & addr_hit & pstrb[0] & ~sys_reset_req;
  // reserved bits are kept as written, so software sees exactly what it stored
  assign ctrl_d      = write_fire ? pwdata[7:0] : ctrl_q;
  // answer is prepared in a setup cycle without sys_reset_req, so the access phase has no wait state; after one with it pready stays low
  assign pready_d    = setup_phase;
  assign pslverr_d   = setup_phase & ~addr_hit;
  assign prdata_d    = (setup_phase & addr_hit & ~pwrite) ? {24'h00_0000, ctrl_q} : pgate_pkg::RDATA_ZERO;

  // ---------------------------------------------------------------
  // control register: loaded with CTRL_RESET by power-on reset only
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= pgate_pkg::CTRL_RESET;
    else
      ctrl_q <= ctrl_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= pgate_pkg::RDATA_ZERO;
    end
    else
    begin
      pready  <= pready_d;
      pslverr <= pslverr_d;
      prdata  <= prdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_value <= pgate_pkg::CTRL_RESET;
    else
      ctrl_value <= ctrl_d;
  end

  // ---------------------------------------------------------------
  // peripheral gating
  // ---------------------------------------------------------------
  logic bod_want;
  logic adc_want;
  logic comp_want;

  // brown-out needs both the register and the nonvolatile option
  assign bod_want  = ~ctrl_q[pgate_pkg::BOD_BIT] & opt_sync_q;
  assign adc_want  = ~ctrl_q[pgate_pkg::ADC_BIT];
  assign comp_want = ~ctrl_q[pgate_pkg::COMP_BIT];

  periph_gate u_gate_bod (
    .pclk     (pclk),
    .presetn  (presetn),
    .want_on  (bod_want),
    .clk_en_q (periph_clk_en.bod),
    .pwr_en_q (periph_pwr_en.bod)
  );

  periph_gate u_gate_adc (
    .pclk     (pclk),
    .presetn  (presetn),
    .want_on  (adc_want),
    .clk_en_q (periph_clk_en.adc),
    .pwr_en_q (periph_pwr_en.adc)
  );

  periph_gate u_gate_comp (
    .pclk     (pclk),
    .presetn  (presetn),
    .want_on  (comp_want),
    .clk_en_q (periph_clk_en.comp),
    .pwr_en_q (periph_pwr_en.comp)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_bod_off;
    (ctrl_q[pgate_pkg::BOD_BIT] || !opt_sync_q) [*3];
  endsequence

  sequence s_bod_on;
    (!ctrl_q[pgate_pkg::BOD_BIT] && opt_sync_q) [*3];
  endsequence

  sequence s_adc_off;
    ctrl_q[pgate_pkg::ADC_BIT] [*3];
  endsequence

  sequence s_adc_on;
    !ctrl_q[pgate_pkg::ADC_BIT] [*3];
  endsequence

  sequence s_comp_off;
    ctrl_q[pgate_pkg::COMP_BIT] [*3];
  endsequence

  property p_sys_reset_keeps;
    sys_reset_req |=> ctrl_q == $past(ctrl_q);
  endproperty
  a_sys_reset_keeps: assert property (p_sys_reset_keeps) else $error("system reset changed control register");

  property p_write_stores;
    (psel && penable && pready && pwrite && addr_hit && pstrb[0] && !sys_reset_req)
      |=> ctrl_q == $past(pwdata[7:0]) && ctrl_value == ctrl_q;
  endproperty
  a_write_stores: assert property (p_write_stores) else $error("write data not stored");

  property p_read_returns;
    (psel && !penable && !pwrite && addr_hit && !sys_reset_req)
      |=> pready && !pslverr && prdata == {24'h00_0000, ctrl_q};
  endproperty
  a_read_returns: assert property (p_read_returns) else $error("read data differs from register");

  property p_unmapped_err;
    (psel && !penable && !addr_hit && !sys_reset_req) |=> pready && pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not flagged");

  property p_bod_off;
    s_bod_off |-> !periph_clk_en.bod ##0 (!periph_pwr_en.bod);
  endproperty
  a_bod_off: assert property (p_bod_off) else $error("brown-out detector still running");

  property p_bod_on;
    s_bod_on |-> periph_clk_en.bod && periph_pwr_en.bod;
  endproperty
  a_bod_on: assert property (p_bod_on) else $error("brown-out detector not enabled");

  property p_adc_gate;
    s_adc_off |-> !periph_clk_en.adc && !periph_pwr_en.adc;
  endproperty
  a_adc_gate: assert property (p_adc_gate) else $error("adc not disabled");

  property p_adc_on;
    s_adc_on |-> periph_clk_en.adc && periph_pwr_en.adc;
  endproperty
  a_adc_on: assert property (p_adc_on) else $error("adc not enabled");

  property p_comp_gate;
    s_comp_off |-> !periph_clk_en.comp && !periph_pwr_en.comp;
  endproperty
  a_comp_gate: assert property (p_comp_gate) else $error("comparator not disabled");

  property p_clk_needs_power;
    (periph_clk_en.adc |-> periph_pwr_en.adc) and
    (periph_clk_en.comp |-> periph_pwr_en.comp) and
    (periph_clk_en.bod |-> periph_pwr_en.bod);
  endproperty
  a_clk_needs_power: assert property (p_clk_needs_power) else $error("clock running without power");

  property p_power_follows_clock;
    $fell(periph_pwr_en.adc) |-> !$past(periph_clk_en.adc);
  endproperty
  a_power_follows_clock: assert property (p_power_follows_clock) else $error("power cut before clock stopped");

endmodule

// *** shared/pgate_pkg.sv ***
// shared constants and types for the peripheral disable control block
package pgate_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W     = 12;
  localparam logic [11:0] CTRL_OFFSET = 12'h0f80;
  localparam logic [7:0]  CTRL_RESET  = 8'h80;
  localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

  // ---------------------------------------------------------------
  // field positions inside the control register
  // ---------------------------------------------------------------
  localparam int unsigned BOD_BIT  = 4;
  localparam int unsigned ADC_BIT  = 2;
  localparam int unsigned COMP_BIT = 1;

  // one bit per gated peripheral
  typedef struct packed {
    logic bod;
    logic adc;
    logic comp;
  } periph_en_t;

endpackage

// *** src/periph_gate.sv ***
// clock and power enable sequencer for one gated peripheral
module periph_gate (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic want_on,
  output logic      clk_en_q,
  output logic      pwr_en_q
);

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  // power comes up one cycle before the clock and goes down one cycle
  // after it, so the block never sees a clock while unpowered
  logic pwr_en_d;
  logic clk_en_d;

  assign pwr_en_d = want_on | clk_en_q;
  assign clk_en_d = want_on & pwr_en_q;

  // start off; the enables follow the control register within two edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwr_en_q <= 1'b0;
      clk_en_q <= 1'b0;
    end
    else
    begin
      pwr_en_q <= pwr_en_d;
      clk_en_q <= clk_en_d;
    end
  end

endmodule

// *** test/periph_disable_ctrl_test.sv ***
// self-checking bench for the peripheral disable control register
module periph_disable_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                           pclk = 1'b0;
  logic                           presetn = 1'b0;
  logic                           sys_reset_req = 1'b0;
  logic                           psel = 1'b0;
  logic                           penable = 1'b0;
  logic                           pwrite = 1'b0;
  logic [pgate_pkg::ADDR_W-1:0]   paddr = '0;
  logic [31:0]                    pwdata = '0;
  logic [3:0]                     pstrb = 4'hf;
  logic [31:0]                    prdata;
  logic                           pready;
  logic                           pslverr;
  logic                           opt = 1'b1;
  pgate_pkg::periph_en_t          clk_en;
  pgate_pkg::periph_en_t          pwr_en;
  logic [7:0]                     ctrl_value;
  logic [31:0]                    rd;
  logic                           err;
  int                             error_cnt = 0;
  int                             checks_done = 0;

  periph_disable_ctrl dut_u (
    .pclk                      (pclk),
    .presetn                   (presetn),
    .sys_reset_req             (sys_reset_req),
    .psel                      (psel),
    .penable                   (penable),
    .pwrite                    (pwrite),
    .paddr                     (paddr),
    .pwdata                    (pwdata),
    .pstrb                     (pstrb),
    .prdata                    (prdata),
    .pready                    (pready),
    .pslverr                   (pslverr),
    .brownout_always_on_option (opt),
    .periph_clk_en             (clk_en),
    .periph_pwr_en             (pwr_en),
    .ctrl_value                (ctrl_value)
  );

  initial
  begin
    forever #20 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a wait for pready
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // expected enables: a set disable bit turns the peripheral off, bod also needs the option
  task automatic chk_gates(input logic [7:0] v);
    logic [2:0] e;
    repeat (6) @(posedge pclk);
    // option level taken after the wait, so a change just before the call is seen
    e = {~v[4] & opt, ~v[2], ~v[1]};
    chk(32'(clk_en), 32'(e), "clock enables");
    chk(32'(pwr_en), 32'(e), "power enables");
  endtask

  task automatic chk_reg(input logic [7:0] v);
    apb(1'b0, pgate_pkg::CTRL_OFFSET, 32'h0000_0000);
    chk(rd, {24'h00_0000, v}, "read back");
    chk(32'(err), 32'h0000_0000, "read error flag");
    chk(32'(ctrl_value), 32'(v), "register copy");
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_por;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk_reg(pgate_pkg::CTRL_RESET);
    chk_gates(pgate_pkg::CTRL_RESET);
    $display("test power-on reset done");
  endtask

  task automatic t_bits;
    logic [7:0] tbl [5] = '{8'h90, 8'h84, 8'h82, 8'h96, 8'h80};
    foreach (tbl[i])
    begin
      apb(1'b1, pgate_pkg::CTRL_OFFSET, {24'h00_0000, tbl[i]});
      chk_reg(tbl[i]);
      chk_gates(tbl[i]);
    end
    $display("test disable bits done");
  endtask

  task automatic t_reserved;
    apb(1'b1, pgate_pkg::CTRL_OFFSET, 32'hffff_ff69);
    chk_reg(8'h69);
    chk_gates(8'h69);
    $display("test reserved bits done");
  endtask

  task automatic t_option;
    opt <= 1'b0;
    apb(1'b1, pgate_pkg::CTRL_OFFSET, 32'h0000_0080);
    chk_gates(8'h80);
    opt <= 1'b1;
    chk_gates(8'h80);
    $display("test always-on option done");
  endtask

  task automatic t_sysreset;
    apb(1'b1, pgate_pkg::CTRL_OFFSET, 32'h0000_0094);
    @(posedge pclk);
    sys_reset_req <= 1'b1;
    repeat (3) @(posedge pclk);
    sys_reset_req <= 1'b0;
    chk_reg(8'h94);
    chk_gates(8'h94);
    apb(1'b1, 12'h004, 32'h0000_0080);
    chk(32'(err), 32'h0000_0001, "unmapped error");
    chk(rd, pgate_pkg::RDATA_ZERO, "unmapped data");
    chk_reg(8'h94);
    // low byte strobe off: the write must be dropped
    pstrb <= 4'he;
    apb(1'b1, pgate_pkg::CTRL_OFFSET, 32'h0000_0080);
    pstrb <= 4'hf;
    chk_reg(8'h94);
    // system reset raised in the access phase aborts the write
    @(posedge pclk);
    psel          <= 1'b1;
    pwrite        <= 1'b1;
    paddr         <= pgate_pkg::CTRL_OFFSET;
    pwdata        <= 32'h0000_0080;
    @(posedge pclk);
    penable       <= 1'b1;
    sys_reset_req <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    psel          <= 1'b0;
    penable       <= 1'b0;
    sys_reset_req <= 1'b0;
    chk_reg(8'h94);
    chk_gates(8'h94);
    $display("test system reset done");
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // generous span: the whole run is about two hundred cycles
  initial
  begin
    #(40 * 5000);
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    t_por();
    t_bits();
    t_reserved();
    t_option();
    t_sysreset();
    t_por();
    print_verdict();
  end
endmodule
